// ===== core/channel_retry.v
`timescale 1ns/1ps
`include "fault_mgr_map.vh"

module channel_retry
#(
  parameter QUIET_GRAN = `QUIET_GRAN,
  parameter QW         = 17
)
(
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        granule_i,
  input  wire        faulted_off_i,
  input  wire        retry_nz_i,
  input  wire        on_edge_i,
  input  wire [2:0]  limit_i,
  input  wire [15:0] delay_gran_i,
  output reg         restart_o,
  output reg  [2:0]  count_o
);

  localparam [1:0] ST_IDLE      = 2'h0;
  localparam [1:0] ST_WAIT      = 2'h1;
  localparam [1:0] ST_RESTARTED = 2'h2;
  localparam [1:0] ST_HOLD      = 2'h3;
  localparam integer  QUIET_I    = QUIET_GRAN - 1;
  localparam [QW-1:0] QUIET_LAST = QUIET_I[QW-1:0];

  reg [1:0]    state;
  reg [2:0]    limit_held;
  reg [15:0]   wait_cnt;
  reg [QW-1:0] quiet_cnt;
  wire         allowed;
  wire         quiet_done;

  // limit 0 never allows, 7 always, else count below limit
  assign allowed = (limit_held == `LIMIT_INF) ||
                   (count_o < limit_held);
  assign quiet_done = granule_i && !faulted_off_i &&
                      (quiet_cnt == QUIET_LAST);

  // retry sequencer, one attempt per faulted-off episode
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state      <= ST_IDLE;
      limit_held <= `LIMIT_RST;
      wait_cnt   <= 16'h0000;
      quiet_cnt  <= {QW{1'b0}};
      restart_o  <= 1'b0;
      count_o    <= 3'h0;
    end
    else
    begin
      restart_o <= 1'b0;
      if (faulted_off_i)
        quiet_cnt <= {QW{1'b0}};
      else if (granule_i && !quiet_done)
        quiet_cnt <= quiet_cnt + {{(QW-1){1'b0}}, 1'b1};
      else if (quiet_done)
        quiet_cnt <= {QW{1'b0}};
      if (on_edge_i)
      begin
        // new limit only picked up at off-then-on
        count_o    <= 3'h0;
        limit_held <= limit_i;
        state      <= ST_IDLE;
      end
      else
      begin
        case (state)
          ST_IDLE:
            if (faulted_off_i && retry_nz_i)
            begin
              if (allowed)
              begin
                state    <= ST_WAIT;
                wait_cnt <= delay_gran_i;
              end
              else
                state <= ST_HOLD;
            end
          ST_WAIT:
            if (!faulted_off_i)
              state <= ST_IDLE;
            else if (wait_cnt == 16'h0000)
            begin
              restart_o <= 1'b1;
              if (limit_held != `LIMIT_INF)
                count_o <= count_o + 3'h1;
              state <= ST_RESTARTED;
            end
            else if (granule_i)
              wait_cnt <= wait_cnt - 16'h0001;
          ST_RESTARTED:
            if (!faulted_off_i)
              state <= ST_IDLE;
          ST_HOLD:
            // stays disabled until the fault is cleared elsewhere
            if (!faulted_off_i)
              state <= ST_IDLE;
          default:
            state <= ST_IDLE;
        endcase
        if (quiet_done)
          count_o <= 3'h0;
      end
    end
  end

endmodule // channel_retry

// ===== core/fault_mgr_map.vh
`ifndef FAULT_MGR_MAP_VH
`define FAULT_MGR_MAP_VH

// command codes of the configuration registers
`define CODE_PROP_A       8'hd2
`define CODE_PROP_B       8'hd3
`define CODE_RESP_A       8'hd5
`define CODE_RESP_B       8'hd6
`define CODE_RETRY_LIMIT  8'hf7

// field positions
`define PROP_BIT          0
`define RESP_MSB          3
`define RESP_LSB          0
`define LIMIT_MSB         2
`define LIMIT_LSB         0

// reset values (stand-in for the nonvolatile defaults)
`define PROP_RST          4'h0
`define RESP_RST          4'h0
`define LIMIT_RST         3'h0

// retry limit encodings
`define LIMIT_NONE        3'h0
`define LIMIT_INF         3'h7

// timing
`define CLK_PERIOD_NS     10
`define DEGLITCH_NS       10000
`define DEGLITCH_CYC      ((`DEGLITCH_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define GRANULE_US        200
`define DELAY_MAX_US      13100000
`define DELAY_MAX_GRAN    (`DELAY_MAX_US / `GRANULE_US)
`define QUIET_S           16
`define QUIET_GRAN        (`QUIET_S * 1000000 / `GRANULE_US)
`define SHARE_PERIOD_US   10
`define SHARE_EDGES       (`GRANULE_US / `SHARE_PERIOD_US)

`endif

// ===== core/fault_retry_manager.v
`timescale 1ns/1ps
`include "fault_mgr_map.vh"

module fault_retry_manager
#(
  parameter DEGLITCH_CYC = `DEGLITCH_CYC,
  parameter SHARE_EDGES  = `SHARE_EDGES,
  parameter QUIET_GRAN   = `QUIET_GRAN
)
(
  input  wire        clock_i,
  input  wire        rst_n_i,
  input  wire        bus_write_i,
  input  wire        bus_read_i,
  input  wire [7:0]  bus_code_i,
  input  wire [7:0]  bus_wdata_i,
  input  wire [1:0]  bus_page_i,
  input  wire        bus_page_all_i,
  output reg  [7:0]  bus_rdata_o,
  output reg         bus_rvalid_o,
  output reg         bus_unmapped_o,
  input  wire [23:0] retry_delay_us_i,
  input  wire [3:0]  faulted_off_i,
  input  wire [3:0]  retry_nz_i,
  input  wire [3:0]  chan_on_i,
  input  wire        clear_faults_i,
  input  wire        share_clk_i,
  input  wire        shared_fault_line_a_n_i,
  output reg         shared_fault_line_a_n_o,
  output reg         shared_fault_line_a_n_oe_o,
  input  wire        shared_fault_line_b_n_i,
  output reg         shared_fault_line_b_n_o,
  output reg         shared_fault_line_b_n_oe_o,
  output reg         host_alert_n_o,
  output reg         host_alert_n_oe_o,
  output wire [3:0]  restart_o,
  output reg  [3:0]  ext_shutdown_o,
  output reg  [3:0]  status_set_a_o,
  output reg  [3:0]  status_set_b_o
);

  localparam integer DEG_I      = DEGLITCH_CYC - 1;
  localparam integer SHARE_I    = SHARE_EDGES - 1;
  localparam integer CAP_I      = `DELAY_MAX_GRAN;
  localparam [15:0]  DEG_LAST   = DEG_I[15:0];
  localparam [7:0]   SHARE_LAST = SHARE_I[7:0];
  localparam [15:0]  DELAY_CAP  = CAP_I[15:0];

  // configuration registers
  reg [3:0]  prop_a, prop_b;
  reg [3:0]  resp_a, resp_b;
  reg [2:0]  limit;

  // pin synchronisers, time base, deglitch and edge state
  reg [1:0]  sync_a, sync_b, sync_share;
  reg        share_prev;
  reg [7:0]  share_cnt;
  reg        granule;
  reg [15:0] deg_a, deg_b;
  reg        low_a_held, low_b_held;
  reg [3:0]  on_prev, on_edge;
  reg [15:0] delay_gran;
  wire       low_a, low_b;
  wire [3:0] page_sel, trip, keep;
  wire [3:0] new_a, new_b;

  // retry delay in 200 us granules, rounded, then clamped
  function [15:0] to_granules;
    input [23:0] us;
    reg   [24:0] rounded;
    begin
      rounded = ({1'b0, us} + 25'd100) / 25'd200;
      if (rounded > {9'h000, DELAY_CAP})
        to_granules = DELAY_CAP;
      else
        to_granules = rounded[15:0];
    end
  endfunction

  // channel mask that a paged write touches
  function [3:0] page_mask;
    input [1:0] page;
    input       all;
    begin
      if (all)
        page_mask = 4'hf;
      else
        page_mask = 4'h1 << page;
    end
  endfunction

  assign page_sel = page_mask(bus_page_i, bus_page_all_i);
  assign low_a    = ~sync_a[1];
  assign low_b    = ~sync_b[1];

  // a channel trips only on a deglitched low and a set response bit
  assign new_a = {4{low_a_held}} & resp_a;
  assign new_b = {4{low_b_held}} & resp_b;
  assign trip  = (new_a | new_b) & ~ext_shutdown_o;
  // held off only while a responding line is still low
  assign keep  = ({4{low_a}} & resp_a) | ({4{low_b}} & resp_b);

  // two-flop synchronisers, only stage two is read
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync_a     <= 2'h3;
      sync_b     <= 2'h3;
      sync_share <= 2'h0;
      share_prev <= 1'b0;
    end
    else
    begin
      sync_a     <= {sync_a[0], shared_fault_line_a_n_i};
      sync_b     <= {sync_b[0], shared_fault_line_b_n_i};
      sync_share <= {sync_share[0], share_clk_i};
      share_prev <= sync_share[1];
    end
  end

  // time-base prescaler: share edges into 200 us granules
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      share_cnt <= 8'h00;
      granule   <= 1'b0;
    end
    else
    begin
      granule <= 1'b0;
      if (sync_share[1] && !share_prev)
      begin
        if (share_cnt == SHARE_LAST)
        begin
          share_cnt <= 8'h00;
          granule   <= 1'b1;
        end
        else
          share_cnt <= share_cnt + 8'h01;
      end
    end
  end

  // retry delay registered; the bus value itself is never changed
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      delay_gran <= 16'h0000;
    else
      delay_gran <= to_granules(retry_delay_us_i);
  end

  // off-then-on detect per channel
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      on_prev <= 4'h0;
      on_edge <= 4'h0;
    end
    else
    begin
      on_prev <= chan_on_i;
      on_edge <= chan_on_i & ~on_prev;
    end
  end

  // register writes; reserved bits simply not stored
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      prop_a <= `PROP_RST;
      prop_b <= `PROP_RST;
      resp_a <= `RESP_RST;
      resp_b <= `RESP_RST;
      limit  <= `LIMIT_RST;
    end
    else if (bus_write_i)
    begin
      case (bus_code_i)
        `CODE_PROP_A:
          prop_a <= (prop_a & ~page_sel) |
                    (page_sel & {4{bus_wdata_i[`PROP_BIT]}});
        `CODE_PROP_B:
          prop_b <= (prop_b & ~page_sel) |
                    (page_sel & {4{bus_wdata_i[`PROP_BIT]}});
        `CODE_RESP_A:
          resp_a <= bus_wdata_i[`RESP_MSB:`RESP_LSB];
        `CODE_RESP_B:
          resp_b <= bus_wdata_i[`RESP_MSB:`RESP_LSB];
        `CODE_RETRY_LIMIT:
          limit <= bus_wdata_i[`LIMIT_MSB:`LIMIT_LSB];
        default:
          limit <= limit;
      endcase
    end
  end

  // register reads, answered one cycle later
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bus_rdata_o    <= 8'h00;
      bus_rvalid_o   <= 1'b0;
      bus_unmapped_o <= 1'b0;
    end
    else
    begin
      bus_rvalid_o   <= bus_read_i;
      bus_unmapped_o <= 1'b0;
      if (bus_read_i)
      begin
        case (bus_code_i)
          `CODE_PROP_A:
            bus_rdata_o <= {7'h00, prop_a[bus_page_i]};
          `CODE_PROP_B:
            bus_rdata_o <= {7'h00, prop_b[bus_page_i]};
          `CODE_RESP_A:
            bus_rdata_o <= {4'h0, resp_a};
          `CODE_RESP_B:
            bus_rdata_o <= {4'h0, resp_b};
          `CODE_RETRY_LIMIT:
            bus_rdata_o <= {5'h00, limit};
          default:
          begin
            bus_rdata_o    <= 8'h00;
            bus_unmapped_o <= 1'b1;
          end
        endcase
      end
    end
  end

  // deglitch: line must stay low for the full 10 us window
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      deg_a      <= 16'h0000;
      deg_b      <= 16'h0000;
      low_a_held <= 1'b0;
      low_b_held <= 1'b0;
    end
    else
    begin
      if (!low_a)
      begin
        deg_a      <= 16'h0000;
        low_a_held <= 1'b0;
      end
      else if (deg_a == DEG_LAST)
        low_a_held <= 1'b1;
      else
        deg_a <= deg_a + 16'h0001;
      if (!low_b)
      begin
        deg_b      <= 16'h0000;
        low_b_held <= 1'b0;
      end
      else if (deg_b == DEG_LAST)
        low_b_held <= 1'b1;
      else
        deg_b <= deg_b + 16'h0001;
    end
  end

  // shutdown per channel; release hands turn-on back to the sequencer
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ext_shutdown_o <= 4'h0;
      status_set_a_o <= 4'h0;
      status_set_b_o <= 4'h0;
    end
    else
    begin
      ext_shutdown_o <= (ext_shutdown_o & keep) | trip;
      status_set_a_o <= trip & new_a;
      status_set_b_o <= trip & new_b;
    end
  end

  // alert held until cleared; a new shutdown beats a clear
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      host_alert_n_o    <= 1'b0;
      host_alert_n_oe_o <= 1'b0;
    end
    else
    begin
      host_alert_n_o <= 1'b0;
      if (|trip)
        host_alert_n_oe_o <= 1'b1;
      else if (clear_faults_i)
        host_alert_n_oe_o <= 1'b0;
    end
  end

  // open-drain drive; our own pull also trips local responders
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      shared_fault_line_a_n_o    <= 1'b0;
      shared_fault_line_a_n_oe_o <= 1'b0;
      shared_fault_line_b_n_o    <= 1'b0;
      shared_fault_line_b_n_oe_o <= 1'b0;
    end
    else
    begin
      shared_fault_line_a_n_o    <= 1'b0;
      shared_fault_line_b_n_o    <= 1'b0;
      shared_fault_line_a_n_oe_o <= |(faulted_off_i & prop_a);
      shared_fault_line_b_n_oe_o <= |(faulted_off_i & prop_b);
    end
  end

  // per-channel retry counters
  genvar ch;
  generate
    for (ch = 0; ch < 4; ch = ch + 1)
    begin : g_chan
      channel_retry
      #(
        .QUIET_GRAN (QUIET_GRAN)
      )
      channel_retry_inst
      (
        .clock_i       (clock_i),
        .rst_n_i       (rst_n_i),
        .granule_i     (granule),
        .faulted_off_i (faulted_off_i[ch]),
        .retry_nz_i    (retry_nz_i[ch]),
        .on_edge_i     (on_edge[ch]),
        .limit_i       (limit),
        .delay_gran_i  (delay_gran),
        .restart_o     (restart_o[ch]),
        .count_o       ()
      );
    end
  endgenerate

endmodule // fault_retry_manager

// ===== testbench/fault_peer.sv
`timescale 1ns/1ps
module fault_peer
#(
  parameter HALF_NS = 50
)
(
  input  wire pull_a_i,
  input  wire pull_b_i,
  input  wire dut_oe_a_i,
  input  wire dut_oe_b_i,
  output wire line_a_n_o,
  output wire line_b_n_o,
  output reg  share_clk_o
);
  // wired-and lines with pull-ups: any party pulling low wins
  assign line_a_n_o = ~(pull_a_i | dut_oe_a_i);
  assign line_b_n_o = ~(pull_b_i | dut_oe_b_i);

  // time base runs free; fast here so granules stay short in sim
  initial
  begin
    share_clk_o = 1'b0;
    forever #(HALF_NS) share_clk_o = ~share_clk_o;
  end
endmodule // fault_peer

// ===== testbench/fault_retry_chk.sv
`timescale 1ns/1ps
module fault_retry_chk
#(
  parameter DEGLITCH_CYC = 1000
)
(
  input wire       clock_i,
  input wire       rst_n_i,
  input wire [3:0] faulted_off_i,
  input wire [3:0] retry_nz_i,
  input wire       clear_faults_i,
  input wire       shared_fault_line_a_n_i,
  input wire       shared_fault_line_b_n_i,
  input wire       shared_fault_line_a_n_oe_o,
  input wire       shared_fault_line_b_n_oe_o,
  input wire       host_alert_n_oe_o,
  input wire [3:0] restart_o,
  input wire [3:0] ext_shutdown_o,
  input wire [3:0] status_set_a_o,
  input wire [3:0] status_set_b_o
);
  reg  [15:0] low_run;
  wire        both_high;

  // low run length; sync stages make it a safe lower bound only
  assign both_high = shared_fault_line_a_n_i & shared_fault_line_b_n_i;
  always @(posedge clock_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      low_run <= 16'h0;
    else if (both_high)
      low_run <= 16'h0;
    else if (low_run != 16'hffff)
      low_run <= low_run + 16'h1;
  end

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  // a line trip and what must come with it
  sequence s_trip;
    $rose(|ext_shutdown_o);
  endsequence
  sequence s_alerted;
    host_alert_n_oe_o && ((status_set_a_o | status_set_b_o) != 4'h0);
  endsequence

  property p_line_a;
    (faulted_off_i == 4'h0) |=> !shared_fault_line_a_n_oe_o;
  endproperty
  a_line_a: assert property (p_line_a)
    else $error("line a pulled with no channel faulted");
  property p_line_b;
    (faulted_off_i == 4'h0) |=> !shared_fault_line_b_n_oe_o;
  endproperty
  a_line_b: assert property (p_line_b)
    else $error("line b pulled with no channel faulted");
  property p_deglitch;
    s_trip |-> (low_run >= DEGLITCH_CYC);
  endproperty
  a_deglitch: assert property (p_deglitch)
    else $error("shutdown before line held low long enough");
  property p_release;
    both_high [*4] |=> (ext_shutdown_o == 4'h0);
  endproperty
  a_release: assert property (p_release)
    else $error("channel still held off after lines released");
  property p_alert;
    s_trip |-> s_alerted;
  endproperty
  a_alert: assert property (p_alert)
    else $error("line shutdown without alert and status");
  property p_alert_hold;
    host_alert_n_oe_o && !clear_faults_i |=> host_alert_n_oe_o;
  endproperty
  a_alert_hold: assert property (p_alert_hold)
    else $error("alert dropped without clear");
  property p_restart;
    (restart_o != 4'h0) |->
      ((restart_o & ~($past(faulted_off_i) & $past(retry_nz_i))) == 4'h0);
  endproperty
  a_restart: assert property (p_restart)
    else $error("restart on channel not faulted with retry set");
  property p_one_shot;
    (restart_o != 4'h0) |=> ((restart_o & $past(restart_o)) == 4'h0);
  endproperty
  a_one_shot: assert property (p_one_shot)
    else $error("restart pulse longer than one cycle");
endmodule // fault_retry_chk

bind fault_retry_manager fault_retry_chk
#(
  .DEGLITCH_CYC(DEGLITCH_CYC)
)
fault_retry_chk_inst
(
  .clock_i, .rst_n_i, .faulted_off_i, .retry_nz_i, .clear_faults_i,
  .shared_fault_line_a_n_i, .shared_fault_line_b_n_i,
  .shared_fault_line_a_n_oe_o, .shared_fault_line_b_n_oe_o,
  .host_alert_n_oe_o, .restart_o, .ext_shutdown_o,
  .status_set_a_o, .status_set_b_o
);

// ===== testbench/fault_retry_manager_bench.sv
`timescale 1ns/1ps
module fault_retry_manager_bench;
  localparam [39:0] CODES = 40'hd2d3d5d6f7;
  reg         clock_i, rst_n_i, bus_write_i, bus_read_i;
  reg         bus_page_all_i, clear_faults_i, pull_a, pull_b;
  reg  [7:0]  bus_code_i, bus_wdata_i;
  reg  [1:0]  bus_page_i;
  reg  [23:0] retry_delay_us_i;
  reg  [3:0]  faulted_off_i, retry_nz_i, chan_on_i;
  wire [7:0]  bus_rdata_o;
  wire        bus_rvalid_o, bus_unmapped_o, share_clk_i, host_alert_n_oe_o;
  wire        host_alert_n_o, shared_fault_line_a_n_o, shared_fault_line_b_n_o;
  wire        shared_fault_line_a_n_i, shared_fault_line_b_n_i;
  wire        shared_fault_line_a_n_oe_o, shared_fault_line_b_n_oe_o;
  wire [3:0]  restart_o, ext_shutdown_o, status_set_a_o, status_set_b_o;
  integer     mismatches, compares, cycles, restarts, i;

  fault_retry_manager
  #(
    .DEGLITCH_CYC(4),
    .SHARE_EDGES(2),
    .QUIET_GRAN(5)
  )
  fault_retry_manager_inst
  (
    .clock_i, .rst_n_i, .bus_write_i, .bus_read_i, .bus_code_i,
    .bus_wdata_i, .bus_page_i, .bus_page_all_i, .bus_rdata_o,
    .bus_rvalid_o, .bus_unmapped_o, .retry_delay_us_i, .faulted_off_i,
    .retry_nz_i, .chan_on_i, .clear_faults_i, .share_clk_i,
    .shared_fault_line_a_n_i, .shared_fault_line_a_n_o,
    .shared_fault_line_a_n_oe_o, .shared_fault_line_b_n_i,
    .shared_fault_line_b_n_o, .shared_fault_line_b_n_oe_o,
    .host_alert_n_o, .host_alert_n_oe_o, .restart_o, .ext_shutdown_o,
    .status_set_a_o, .status_set_b_o
  );

  fault_peer fault_peer_inst
  (
    .pull_a_i(pull_a), .pull_b_i(pull_b),
    .dut_oe_a_i(shared_fault_line_a_n_oe_o),
    .dut_oe_b_i(shared_fault_line_b_n_oe_o),
    .line_a_n_o(shared_fault_line_a_n_i),
    .line_b_n_o(shared_fault_line_b_n_i), .share_clk_o(share_clk_i)
  );

  // clock
  initial
  begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
  end

  // restart counter for channel 0 and a watchdog on the run
  always @(posedge clock_i)
  begin
    cycles = cycles + 1;
    if (restart_o[0] === 1'b1)
      restarts = restarts + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      results;
    end
  end

  task tick(input integer n);
  begin
    repeat (n) @(posedge clock_i);
    #1;
  end
  endtask

  task chk(input string name, input [7:0] seen, input [7:0] exp);
  begin
    compares = compares + 1;
    if (seen !== exp)
    begin
      mismatches = mismatches + 1;
      $display("Error %0s expected %h seen %h", name, exp, seen);
    end
  end
  endtask

  // strobe held one edge, then one idle edge before the next request
  task wr(input [7:0] code, input [1:0] page, input [7:0] data);
  begin
    {bus_code_i, bus_page_i, bus_wdata_i} = {code, page, data};
    bus_write_i = 1'b1;
    tick(1);
    bus_write_i = 1'b0;
    tick(1);
  end
  endtask

  // rvalid stands one cycle only, so it is judged right after the strobe
  task rd(input [7:0] code, input [1:0] page, input [7:0] exp);
    reg [7:0] unm;
  begin
    unm = (code inside {8'hd2, 8'hd3, 8'hd5, 8'hd6, 8'hf7}) ? 8'h00 : 8'h01;
    {bus_code_i, bus_page_i, bus_read_i} = {code, page, 1'b1};
    tick(1);
    bus_read_i = 1'b0;
    chk("rvalid", {7'h0, bus_rvalid_o}, 8'h01);
    chk("rdata", bus_rdata_o, exp);
    chk("unmapped", {7'h0, bus_unmapped_o}, unm);
    tick(1);
  end
  endtask

  task toggle;
  begin
    chan_on_i[0] = 1'b0;
    tick(2);
    chan_on_i[0] = 1'b1;
    tick(4);
  end
  endtask

  // eight short fault episodes on channel 0
  task episodes(input [7:0] exp);
  begin
    restarts = 0;
    repeat (8)
    begin
      faulted_off_i = 4'h1;
      tick(10);
      faulted_off_i = 4'h0;
      tick(3);
    end
    chk("restarts", restarts[7:0], exp);
  end
  endtask

  task t_regs;
  begin
    for (i = 0; i < 5; i = i + 1)
      rd(CODES[8*i +: 8], 2'h0, 8'h00);
    rd(8'h55, 2'h0, 8'h00);
    bus_page_all_i = 1'b1;
    wr(8'hd2, 2'h0, 8'h01);
    bus_page_all_i = 1'b0;
    rd(8'hd2, 2'h3, 8'h01);
    bus_page_all_i = 1'b1;
    wr(8'hd2, 2'h0, 8'h00);
    bus_page_all_i = 1'b0;
    rd(8'hd2, 2'h3, 8'h00);
    wr(8'hd2, 2'h1, 8'hff);
    rd(8'hd2, 2'h1, 8'h01);
    rd(8'hd2, 2'h0, 8'h00);
    wr(8'hd3, 2'h2, 8'hfe);
    rd(8'hd3, 2'h2, 8'h00);
    wr(8'hd3, 2'h2, 8'h01);
    wr(8'hd5, 2'h1, 8'hf1);
    rd(8'hd5, 2'h3, 8'h01);
    wr(8'hd6, 2'h0, 8'h04);
    rd(8'hd6, 2'h2, 8'h04);
  end
  endtask

  // kept to one cycle per line so no channel trips on its own pull
  task t_prop;
  begin
    faulted_off_i = 4'h2;
    tick(1);
    chk("oe a", {7'h0, shared_fault_line_a_n_oe_o}, 8'h01);
    chk("oe b", {7'h0, shared_fault_line_b_n_oe_o}, 8'h00);
    chk("drive a", {7'h0, shared_fault_line_a_n_o}, 8'h00);
    chk("drive b", {7'h0, shared_fault_line_b_n_o}, 8'h00);
    faulted_off_i = 4'h4;
    tick(1);
    chk("line a", {7'h0, shared_fault_line_a_n_i}, 8'h01);
    chk("line b", {7'h0, shared_fault_line_b_n_i}, 8'h00);
    faulted_off_i = 4'h0;
    tick(4);
  end
  endtask

  task t_resp;
  begin
    pull_a = 1'b1;
    tick(3);
    pull_a = 1'b0;
    tick(4);
    chk("glitch", {4'h0, ext_shutdown_o}, 8'h00);
    pull_a = 1'b1;
    tick(10);
    chk("shut a", {4'h0, ext_shutdown_o}, 8'h01);
    chk("alert", {7'h0, host_alert_n_oe_o}, 8'h01);
    chk("alert pin", {7'h0, host_alert_n_o}, 8'h00);
    pull_b = 1'b1;
    tick(10);
    chk("shut b", {4'h0, ext_shutdown_o}, 8'h05);
    {pull_a, pull_b} = 2'b00;
    tick(4);
    chk("back on", {4'h0, ext_shutdown_o}, 8'h00);
    clear_faults_i = 1'b1;
    tick(1);
    clear_faults_i = 1'b0;
    tick(1);
    chk("alert clr", {7'h0, host_alert_n_oe_o}, 8'h00);
  end
  endtask

  task t_retry;
  begin
    retry_nz_i = 4'h1;
    for (i = 0; i < 8; i = i + 1)
    begin
      wr(8'hf7, 2'h0, i[7:0]);
      toggle;
      episodes((i == 7) ? 8'h08 : i[7:0]);
    end
    wr(8'hf7, 2'h0, 8'h02);
    episodes(8'h08);
    toggle;
    episodes(8'h02);
    tick(200);
    episodes(8'h02);
    // delay set first so its registered form is in place at the fault
    retry_delay_us_i = 24'd500;
    toggle;
    restarts = 0;
    faulted_off_i = 4'h1;
    tick(38);
    chk("early", restarts[7:0], 8'h00);
    tick(30);
    chk("late", restarts[7:0], 8'h01);
    faulted_off_i = 4'h0;
    retry_delay_us_i = 24'h0;
    retry_nz_i = 4'h0;
    toggle;
    episodes(8'h00);
  end
  endtask

  task results;
  begin
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  end
  endtask

  initial
  begin
    {rst_n_i, bus_write_i, bus_read_i, bus_page_all_i, clear_faults_i} = 5'h0;
    {pull_a, pull_b, bus_code_i, bus_wdata_i, bus_page_i} = 20'h0;
    retry_delay_us_i = 24'h0;
    {faulted_off_i, retry_nz_i} = 8'h0;
    chan_on_i = 4'hf;
    {mismatches, compares, cycles, restarts} = 128'h0;
    repeat (12) @(posedge clock_i);
    #1;
    rst_n_i = 1'b1;
    tick(3);
    t_regs;
    t_prop;
    t_resp;
    t_retry;
    results;
  end
endmodule // fault_retry_manager_bench
